// ===== logic/iasu_pkg.sv
// shared types and constants of the add/sub/logic execution unit
package iasu_pkg;
    // operation codes from the decoder
    typedef enum logic [3:0] {
        IASU_OP_NONE,
        IASU_OP_ADD,
        IASU_OP_ADD_CARRY,
        IASU_OP_SUB,
        IASU_OP_MINUS_CONSTANT,
        IASU_OP_MINUS_WITH_BORROW,
        IASU_OP_CONSTANT_MINUS_WITH_BORROW,
        IASU_OP_PAIR_PLUS_IMMEDIATE,
        IASU_OP_PAIR_MINUS_IMMEDIATE,
        IASU_OP_AND,
        IASU_OP_CONJUNCTION_WITH_CONSTANT,
        IASU_OP_OR,
        IASU_OP_OR_CONSTANT
    } iasu_op_t;

    // status flags kept by the unit
    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } iasu_flags_t;

    // one request from the decoder and register file
    typedef struct packed {
        iasu_op_t op;
        logic [4:0] dst;
        logic [7:0] rd;
        logic [7:0] rd_hi;
        logic [7:0] rr;
        logic [7:0] k;
    } iasu_req_t;

    // register file write-back
    typedef struct packed {
        logic we_lo;
        logic we_hi;
        logic [4:0] addr;
        logic [7:0] lo;
        logic [7:0] hi;
    } iasu_wb_t;

    localparam int IASU_DATA_W = 8;
    localparam int IASU_SINGLE_CYCLES = 1;
    localparam int IASU_PAIR_CYCLES = 2;
    localparam iasu_flags_t IASU_FLAGS_RST = '0;
endpackage

// ===== logic/iasu_unit.sv
// add/sub/logic execution unit: datapath, flags and pair sequencer
// Operation
// - add and add-with-carry, one cycle, ZCNVSH
// - pair plus immediate, two cycles, ZCNVS
// - subtract register or constant, one cycle
// - subtract register and carry, one cycle
// - subtract constant and carry, one cycle
// - pair minus immediate, two cycles, ZCNVS
// - and/or forms: ZNVS only, one cycle
`timescale 1ns/100ps
module iasu_unit #(
    // datapath width; the flag logic is written for eight bits only
    parameter int DATA_W = iasu_pkg::IASU_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request side
    input wire iasu_pkg::iasu_req_t req,
    input wire logic req_valid,
    output logic busy,
    // write-back and flags
    output iasu_pkg::iasu_wb_t wb,
    output iasu_pkg::iasu_flags_t flags
);
    // ==========================================================
    // elaboration checks
    // a wider word would need new half-carry and overflow taps
    if (DATA_W != 8) begin : g_width_check
        $error("iasu_unit serves an eight-bit datapath only");
    end
    // the sequencer has exactly one extra state for word forms
    if (iasu_pkg::IASU_SINGLE_CYCLES != 1
        || iasu_pkg::IASU_PAIR_CYCLES != 2) begin : g_cycle_check
        $error("iasu_unit serves one-cycle byte and two-cycle word forms only");
    end

    // ==========================================================
    // state
    typedef enum logic {IASU_IDLE, IASU_PAIR2} iasu_state_t;

    // all state of the unit in one word
    typedef struct packed {
        iasu_state_t st;
        logic busy;
        iasu_pkg::iasu_wb_t wb;
        iasu_pkg::iasu_flags_t fl;
        logic [15:0] pair;
    } iasu_state_s_t;

    // pair holds the word result between the flag cycle and the write cycle
    iasu_state_s_t s_q;
    iasu_state_s_t s_d;

    // ==========================================================
    // datapath temporaries, all set at the top of the process
    logic [8:0] sum;
    logic [7:0] b;
    logic [7:0] r;
    logic cin;
    logic [16:0] wsum;
    logic [15:0] wres;

    // ==========================================================
    // next state
    // write enables are one-cycle pulses, cleared unless an op sets them
    always_comb begin
        s_d = s_q;
        s_d.wb.we_lo = 1'b0;
        s_d.wb.we_hi = 1'b0;
        b = 8'h00;
        r = 8'h00;
        cin = 1'b0;
        sum = 9'h000;
        wsum = 17'h00000;
        wres = 16'h0000;
        case (s_q.st)
            IASU_IDLE: begin
                s_d.busy = 1'b0;
                // operands are sampled only here; a request while busy is dropped
                // without notice, so the decoder must hold off for that cycle
                if (req_valid) begin
                    case (req.op)
                        iasu_pkg::IASU_OP_ADD, iasu_pkg::IASU_OP_ADD_CARRY: begin
                            // carry-in only for the carry form
                            cin = (req.op == iasu_pkg::IASU_OP_ADD_CARRY) ? s_q.fl.c : 1'b0;
                            sum = {1'b0, req.rd} + {1'b0, req.rr} + {8'h00, cin};
                            r = sum[7:0];
                            s_d.fl.c = sum[8];
                            // half carry out of bit three
                            s_d.fl.h = (req.rd[3] & req.rr[3]) | (req.rr[3] & ~r[3])
                                | (~r[3] & req.rd[3]);
                            // overflow: equal signs in, other sign out
                            s_d.fl.v = (req.rd[7] & req.rr[7] & ~r[7])
                                | (~req.rd[7] & ~req.rr[7] & r[7]);
                            s_d.fl.n = r[7];
                            s_d.fl.z = (r == 8'h00);
                            s_d.fl.s = r[7] ^ s_d.fl.v;
                            s_d.wb.we_lo = 1'b1;
                        end

                        iasu_pkg::IASU_OP_SUB, iasu_pkg::IASU_OP_MINUS_CONSTANT,
                        iasu_pkg::IASU_OP_MINUS_WITH_BORROW,
                        iasu_pkg::IASU_OP_CONSTANT_MINUS_WITH_BORROW: begin
                            // register forms take rr, constant forms take k
                            b = (req.op == iasu_pkg::IASU_OP_SUB
                                || req.op == iasu_pkg::IASU_OP_MINUS_WITH_BORROW)
                                ? req.rr : req.k;
                            cin = (req.op == iasu_pkg::IASU_OP_MINUS_WITH_BORROW
                                || req.op == iasu_pkg::IASU_OP_CONSTANT_MINUS_WITH_BORROW)
                                ? s_q.fl.c : 1'b0;
                            sum = {1'b0, req.rd} - {1'b0, b} - {8'h00, cin};
                            r = sum[7:0];
                            s_d.fl.c = sum[8];
                            // borrow into bit four
                            s_d.fl.h = (~req.rd[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~req.rd[3]);
                            // overflow: unlike signs in, sign of subtrahend out
                            s_d.fl.v = (req.rd[7] & ~b[7] & ~r[7]) | (~req.rd[7] & b[7] & r[7]);
                            s_d.fl.n = r[7];
                            // borrow forms with the carry set keep zero only when the chain stays zero
                            s_d.fl.z = (r == 8'h00) & (cin ? s_q.fl.z : 1'b1);
                            s_d.fl.s = r[7] ^ s_d.fl.v;
                            s_d.wb.we_lo = 1'b1;
                        end

                        // logic forms leave c and h alone
                        iasu_pkg::IASU_OP_AND, iasu_pkg::IASU_OP_CONJUNCTION_WITH_CONSTANT,
                        iasu_pkg::IASU_OP_OR, iasu_pkg::IASU_OP_OR_CONSTANT: begin
                            // register forms take rr, constant forms take k
                            b = (req.op == iasu_pkg::IASU_OP_AND
                                || req.op == iasu_pkg::IASU_OP_OR) ? req.rr : req.k;
                            r = (req.op == iasu_pkg::IASU_OP_AND
                                || req.op == iasu_pkg::IASU_OP_CONJUNCTION_WITH_CONSTANT)
                                ? (req.rd & b) : (req.rd | b);
                            // overflow cleared, so sign equals negative
                            s_d.fl.v = 1'b0;
                            s_d.fl.n = r[7];
                            s_d.fl.z = (r == 8'h00);
                            s_d.fl.s = r[7];
                            s_d.wb.we_lo = 1'b1;
                        end

                        iasu_pkg::IASU_OP_PAIR_PLUS_IMMEDIATE,
                        iasu_pkg::IASU_OP_PAIR_MINUS_IMMEDIATE: begin
                            // carry and overflow from the sign bits of operand and result
                            if (req.op == iasu_pkg::IASU_OP_PAIR_PLUS_IMMEDIATE) begin
                                wsum = {1'b0, req.rd_hi, req.rd} + {9'h000, req.k};
                                s_d.fl.v = ~req.rd_hi[7] & wsum[15];
                                s_d.fl.c = ~wsum[15] & req.rd_hi[7];
                            end else begin
                                wsum = {1'b0, req.rd_hi, req.rd} - {9'h000, req.k};
                                s_d.fl.v = req.rd_hi[7] & ~wsum[15];
                                s_d.fl.c = wsum[15] & ~req.rd_hi[7];
                            end
                            wres = wsum[15:0];
                            s_d.fl.n = wres[15];
                            s_d.fl.z = (wres == 16'h0000);
                            s_d.fl.s = wres[15] ^ s_d.fl.v;
                            // flags land now; the write waits so both bytes go together
                            s_d.pair = wres;
                            s_d.busy = 1'b1;
                            s_d.st = IASU_PAIR2;
                        end

                        // no operation: nothing written, flags kept
                        iasu_pkg::IASU_OP_NONE: begin
                            r = 8'h00;
                        end
                        default: begin
                            r = 8'h00;
                        end
                    endcase
                    // address follows every taken op, even one that writes nothing
                    s_d.wb.addr = req.dst;
                    if (s_d.wb.we_lo) begin
                        s_d.wb.lo = r;
                    end
                end
            end

            // both bytes written in one edge, busy until then
            IASU_PAIR2: begin
                // addr still holds the low register of the pair
                s_d.wb.lo = s_q.pair[7:0];
                s_d.wb.hi = s_q.pair[15:8];
                s_d.wb.we_lo = 1'b1;
                s_d.wb.we_hi = 1'b1;
                s_d.busy = 1'b0;
                s_d.st = IASU_IDLE;
            end
            // an undefined state falls back to idle without writing
            default: begin
                s_d.st = IASU_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    // synchronous reset; flags take their own reset value
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= IASU_IDLE;
            s_q.fl <= iasu_pkg::IASU_FLAGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from the state register
    assign busy = s_q.busy;
    assign wb = s_q.wb;
    assign flags = s_q.fl;
endmodule // iasu_unit

// ===== verif/iasu_chk.sv
// bound checker of the add/sub/logic unit
`timescale 1ns/100ps
module iasu_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire iasu_pkg::iasu_req_t req,
    input wire logic req_valid,
    input wire logic busy,
    input wire iasu_pkg::iasu_wb_t wb,
    input wire iasu_pkg::iasu_flags_t flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire tk = req_valid && !busy;
    wire [7:0] add_w = req.rd + req.rr;
    wire [7:0] sub_w = req.rd - req.rr;
    wire [15:0] pp_w = {req.rd_hi, req.rd} + {8'h00, req.k};
    wire [15:0] pm_w = {req.rd_hi, req.rd} - {8'h00, req.k};
    wire pr = req.op inside {iasu_pkg::IASU_OP_PAIR_PLUS_IMMEDIATE,
        iasu_pkg::IASU_OP_PAIR_MINUS_IMMEDIATE};
    a_add_sum: assert property (tk && req.op == iasu_pkg::IASU_OP_ADD
        |=> wb.we_lo && wb.lo == $past(add_w)) else $error("add result wrong");
    a_sub_diff: assert property (tk && req.op == iasu_pkg::IASU_OP_SUB
        |=> wb.we_lo && wb.lo == $past(sub_w)) else $error("sub result wrong");
    a_borrow_diff: assert property (tk && req.op == iasu_pkg::IASU_OP_MINUS_WITH_BORROW
        |=> wb.lo == $past(sub_w) - $past(flags.c)) else $error("borrow result wrong");
    a_pair_timing: assert property (tk && pr
        |=> busy && !wb.we_lo ##1 !busy && wb.we_lo && wb.we_hi) else $error("pair timing wrong");
    a_pair_plus: assert property (tk && req.op == iasu_pkg::IASU_OP_PAIR_PLUS_IMMEDIATE
        |-> ##2 {wb.hi, wb.lo} == $past(pp_w, 2)) else $error("pair sum wrong");
    a_pair_minus: assert property (tk && req.op == iasu_pkg::IASU_OP_PAIR_MINUS_IMMEDIATE
        |-> ##2 {wb.hi, wb.lo} == $past(pm_w, 2)) else $error("pair diff wrong");
    a_logic_keep: assert property (tk && req.op == iasu_pkg::IASU_OP_AND
        |=> flags.c == $past(flags.c) && flags.h == $past(flags.h)) else $error("logic flags");
    a_refuse_busy: assert property (busy && req_valid ##1 !req_valid
        |-> !busy ##1 !wb.we_lo) else $error("request taken while busy");
    c_pair: cover property (tk && pr);
    c_carry_add: cover property (tk && req.op == iasu_pkg::IASU_OP_ADD_CARRY);
    c_refused: cover property (busy && req_valid);
endmodule // iasu_chk
bind iasu_unit iasu_chk i_iasu_chk (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
    .busy(busy), .wb(wb), .flags(flags));

// ===== verif/iasu_rf_model.sv
// register file model taking the unit's write-back
`timescale 1ns/100ps
module iasu_rf_model (
    // clock
    input wire logic clk,
    // write-back and read port
    input wire iasu_pkg::iasu_wb_t wb,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] regs_q [32];
    // high byte lands one register above the low one
    always_ff @(posedge clk) begin
        if (wb.we_lo) begin
            regs_q[wb.addr] <= wb.lo;
        end
        if (wb.we_hi) begin
            regs_q[wb.addr + 5'h01] <= wb.hi;
        end
    end
    assign rdata = regs_q[raddr];
endmodule // iasu_rf_model

// ===== verif/integer_add_sub_logic_unit_bench.sv
// self-checking bench of the add/sub/logic unit
`timescale 1ns/100ps
module integer_add_sub_logic_unit_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    iasu_pkg::iasu_req_t req = '0;
    logic req_valid = 1'b0;
    logic busy;
    iasu_pkg::iasu_wb_t wb;
    iasu_pkg::iasu_flags_t flags;
    logic [4:0] raddr = 5'h18;
    logic [7:0] rdata;
    int failures = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    iasu_unit i_iasu_unit (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
        .busy(busy), .wb(wb), .flags(flags));
    iasu_rf_model i_iasu_rf_model (.clk(clk), .wb(wb), .raddr(raddr), .rdata(rdata));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one request; returns just after the taking edge
    task issue(input iasu_pkg::iasu_op_t op, input logic [7:0] rd, hi, rr, k);
        @(posedge clk);
        req <= '{op, 5'h18, rd, hi, rr, k};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
    endtask
    task t_add;
        issue(iasu_pkg::IASU_OP_ADD, 8'hf0, 8'h00, 8'h20, 8'h00);
        chk({flags.c, wb.lo}, 16'h0110);
        issue(iasu_pkg::IASU_OP_ADD_CARRY, 8'h01, 8'h00, 8'h01, 8'h00);
        chk(wb.lo, 16'h0003);
    endtask
    task t_sub;
        issue(iasu_pkg::IASU_OP_SUB, 8'h10, 8'h00, 8'h20, 8'h00);
        chk({flags.c, wb.lo}, 16'h01f0);
        issue(iasu_pkg::IASU_OP_MINUS_WITH_BORROW, 8'h05, 8'h00, 8'h01, 8'h00);
        chk({flags.c, wb.lo}, 16'h0003);
        issue(iasu_pkg::IASU_OP_CONSTANT_MINUS_WITH_BORROW, 8'h00, 8'h00, 8'h00, 8'h01);
        chk({flags.c, wb.lo}, 16'h01ff);
        issue(iasu_pkg::IASU_OP_MINUS_CONSTANT, 8'h08, 8'h00, 8'h00, 8'h08);
        chk({flags.z, wb.lo}, 16'h0100);
    endtask
    task t_pair;
        issue(iasu_pkg::IASU_OP_PAIR_PLUS_IMMEDIATE, 8'hff, 8'h00, 8'h00, 8'h01);
        chk({busy, wb.we_lo}, 16'h0002);
        chk({flags.s, flags.v, flags.n, flags.z, flags.c}, 16'h0000);
        @(posedge clk) #1;
        chk({busy, wb.we_hi, wb.hi}, 16'h0101);
        chk({wb.hi, wb.lo}, 16'h0100);
        chk(wb.addr, 16'h0018);
        @(posedge clk) #1;
        raddr = 5'h19;
        #1 chk(rdata, 16'h0001);
        issue(iasu_pkg::IASU_OP_PAIR_MINUS_IMMEDIATE, 8'h00, 8'h80, 8'h00, 8'h01);
        chk({flags.s, flags.v, flags.n, flags.z, flags.c}, 16'h0018);
        // refused request in the busy cycle
        req.op <= iasu_pkg::IASU_OP_ADD;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        #1 chk({wb.hi, wb.lo}, 16'h7fff);
        @(posedge clk) #1 chk(wb.we_lo, 16'h0000);
    endtask
    task t_logic;
        issue(iasu_pkg::IASU_OP_ADD, 8'hff, 8'h00, 8'h01, 8'h00);
        issue(iasu_pkg::IASU_OP_AND, 8'hf0, 8'h00, 8'h3c, 8'h00);
        chk({flags.h, flags.c, wb.lo}, 16'h0330);
        issue(iasu_pkg::IASU_OP_CONJUNCTION_WITH_CONSTANT, 8'h81, 8'h00, 8'h00, 8'h80);
        chk({flags.n, flags.z, wb.lo}, 16'h0280);
        issue(iasu_pkg::IASU_OP_OR, 8'h00, 8'h00, 8'h00, 8'h00);
        chk({flags.z, flags.v, wb.lo}, 16'h0200);
        issue(iasu_pkg::IASU_OP_ADD, 8'h7f, 8'h00, 8'h01, 8'h00);
        chk({flags.v, flags.n, wb.lo}, 16'h0380);
        issue(iasu_pkg::IASU_OP_OR_CONSTANT, 8'h01, 8'h00, 8'h00, 8'h80);
        chk({flags.h, flags.c, flags.v, flags.n, wb.lo}, 16'h0981);
    endtask
    task end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 chk(flags, 16'h0000);
        t_add;
        t_sub;
        t_pair;
        t_logic;
        end_sim;
    end
    initial begin
        #40000;
        failures++;
        end_sim;
    end
endmodule // integer_add_sub_logic_unit_bench
